/* File: hdl/scic_cfg.svh */
`ifndef SCIC_CFG_SVH
`define SCIC_CFG_SVH

`define SCIC_POS_OFS 8'h22
`define SCIC_MODE_OFS 8'h30
`define SCIC_QCTL_OFS 8'h31

`define SCIC_INIT_BIT 7
`define SCIC_EXT_BIT 0
`define SCIC_PONE_BIT 1
`define SCIC_SERR_BIT 7

`define SCIC_P_BIT 7
`define SCIC_Q_BIT 6

`define SCIC_POS_RST 7'h00
`define SCIC_QCTL_RST 8'h00
`define SCIC_FRAME_LEN 98
`define SCIC_Q_FIRST 7'h02
`define SCIC_CRC_BITS 16
`define SCIC_Q_DATA_BITS 80
`define SCIC_CRC_POLY 16'h1021
`define SCIC_CRC_INIT 16'h0000

`endif

/* File: hdl/scic_pkg.sv */
package scic_pkg;

   typedef enum logic [1:0] {
      SLOT_SYNC = 2'b00,
      SLOT_DATA = 2'b01,
      SLOT_CRC = 2'b10
   } scic_slot_type;

   typedef struct packed {
      logic sync;
      logic [7:0] data;
   } scic_link_type;

   typedef struct packed {
      logic valid;
      logic s0;
      logic s1;
      logic [7:0] data;
   } scic_out_type;

endpackage : scic_pkg

/* File: hdl/scic_crc16.sv */
`timescale 1ns/10ps
`include "scic_cfg.svh"

module scic_crc16 (
   input wire logic clk,
   input wire logic srst,
   input wire logic init,
   input wire logic shift,
   input wire logic din,
   output logic [15:0] crc
);

   logic [15:0] next_crc;
   logic fb;

   always_comb begin
      fb = crc[15] ^ din;
      next_crc = crc;
      if (init) begin
         next_crc = `SCIC_CRC_INIT;
      end else if (shift) begin
         next_crc = {crc[14:0], 1'b0} ^ (fb ? `SCIC_CRC_POLY : 16'h0000);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         crc <= `SCIC_CRC_INIT;
      end else begin
         crc <= next_crc;
      end
   end

endmodule : scic_crc16

/* File: hdl/scic_subcode_insert.sv */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "scic_cfg.svh"

module scic_subcode_insert #(
   parameter int FRAME_LEN = `SCIC_FRAME_LEN
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic BYTE_TICK,
   input wire scic_pkg::scic_link_type SRI_IN,
   output scic_pkg::scic_out_type SUB_OUT,
   output logic SYNC_ERR
);

   localparam logic [6:0] LAST = 7'(FRAME_LEN - 1);
   localparam logic [6:0] CRC_POS = 7'(FRAME_LEN - `SCIC_CRC_BITS);

   generate
      if (FRAME_LEN < 19 || FRAME_LEN > `SCIC_FRAME_LEN) begin : g_chk
         $error("FRAME_LEN out of range");
      end
   endgenerate

   // classify a frame position
   function automatic scic_pkg::scic_slot_type slot_of(
      input logic [6:0] p
   );
      if (p < `SCIC_Q_FIRST) begin
         return scic_pkg::SLOT_SYNC;
      end else if (p >= CRC_POS) begin
         return scic_pkg::SLOT_CRC;
      end else begin
         return scic_pkg::SLOT_DATA;
      end
   endfunction : slot_of

   // register state
   logic init_frame, next_init_frame;
   logic [6:0] preset_position, next_preset_position;
   logic ext_sel, next_ext_sel;
   logic p_one, next_p_one;
   logic [7:0] q_ctrl, next_q_ctrl;
   logic [7:0] next_rdata;
   logic next_sync_err;

   // frame state
   logic running, next_running;
   logic [6:0] current_position, next_current_position;
   logic [15:0] frame_cnt, next_frame_cnt;
   scic_pkg::scic_out_type next_sub_out;

   logic wr_pos, wr_mode, wr_qctl, emit, crc_init, crc_shift, q_bit;
   logic [15:0] crc_val;
   logic [`SCIC_Q_DATA_BITS-1:0] q_word;
   logic [6:0] q_idx, c_idx;
   scic_pkg::scic_slot_type slot;

   assign wr_pos = WR && ADDR == `SCIC_POS_OFS;
   assign wr_mode = WR && ADDR == `SCIC_MODE_OFS;
   assign wr_qctl = WR && ADDR == `SCIC_QCTL_OFS;
   assign emit = BYTE_TICK && running && !init_frame;
   assign slot = slot_of(current_position);
   assign q_idx = current_position - `SCIC_Q_FIRST;
   assign c_idx = current_position - CRC_POS;
   // internal Q word: control byte then running frame number
   assign q_word = {q_ctrl, (`SCIC_Q_DATA_BITS - 8)'(frame_cnt)};

   // register block
   always_comb begin
      next_init_frame = init_frame;
      next_preset_position = preset_position;
      next_ext_sel = ext_sel;
      next_p_one = p_one;
      next_q_ctrl = q_ctrl;
      next_sync_err = SYNC_ERR;
      next_rdata = 8'h00;
      if (init_frame && BYTE_TICK) begin
         next_init_frame = 1'b0;
      end
      if (wr_pos) begin
         next_preset_position = WDATA[6:0];
         if (WDATA[`SCIC_INIT_BIT]) begin
            next_init_frame = 1'b1;
         end
      end
      if (wr_mode) begin
         next_ext_sel = WDATA[`SCIC_EXT_BIT];
         next_p_one = WDATA[`SCIC_PONE_BIT];
         if (WDATA[`SCIC_SERR_BIT]) begin
            next_sync_err = 1'b0;
         end
      end
      if (wr_qctl) begin
         next_q_ctrl = WDATA;
      end
      // link sync must mark position 0; set wins over clear
      if (emit && ext_sel && SRI_IN.sync != (current_position == 7'h00)) begin
         next_sync_err = 1'b1;
      end
      if (RD) begin
         unique case (ADDR)
            `SCIC_POS_OFS: next_rdata = {init_frame, current_position};
            `SCIC_MODE_OFS: next_rdata = {SYNC_ERR, 5'h00, p_one, ext_sel};
            `SCIC_QCTL_OFS: next_rdata = q_ctrl;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         init_frame <= 1'b0;
         preset_position <= `SCIC_POS_RST;
         ext_sel <= 1'b0;
         p_one <= 1'b0;
         q_ctrl <= `SCIC_QCTL_RST;
         SYNC_ERR <= 1'b0;
         RDATA <= 8'h00;
      end else begin
         init_frame <= next_init_frame;
         preset_position <= next_preset_position;
         ext_sel <= next_ext_sel;
         p_one <= next_p_one;
         q_ctrl <= next_q_ctrl;
         SYNC_ERR <= next_sync_err;
         RDATA <= next_rdata;
      end
   end

   // Q CRC runs over the outgoing Q data bits in either mode
   assign q_bit = ext_sel ? SRI_IN.data[`SCIC_Q_BIT]
                          : q_word[`SCIC_Q_DATA_BITS - 1 - int'(q_idx)];
   assign crc_init = (init_frame && BYTE_TICK)
                     || (emit && current_position == 7'h01);
   assign crc_shift = emit && slot == scic_pkg::SLOT_DATA;

   scic_crc16 u_crc (
      .clk(REF_CLK),
      .srst(SRST),
      .init(crc_init),
      .shift(crc_shift),
      .din(q_bit),
      .crc(crc_val)
   );

   // frame sequencing and byte assembly
   always_comb begin
      next_running = running;
      next_current_position = current_position;
      next_frame_cnt = frame_cnt;
      next_sub_out = '0;
      if (init_frame && BYTE_TICK) begin
         next_running = 1'b1;
         next_current_position = preset_position;
      end else if (emit) begin
         next_current_position = (current_position == LAST) ? 7'h00
                                 : current_position + 7'h01;
         if (current_position == LAST && !ext_sel) begin
            next_frame_cnt = frame_cnt + 16'h0001;
         end
         next_sub_out.valid = 1'b1;
         unique case (slot)
            scic_pkg::SLOT_SYNC: begin
               // sync bytes are made here, never taken from the link
               next_sub_out.s0 = current_position == 7'h00;
               next_sub_out.s1 = current_position == 7'h01;
            end
            scic_pkg::SLOT_DATA: begin
               if (ext_sel) begin
                  next_sub_out.data = SRI_IN.data;
               end else begin
                  next_sub_out.data[`SCIC_P_BIT] = p_one;
                  next_sub_out.data[`SCIC_Q_BIT] = q_bit;
               end
            end
            default: begin
               if (ext_sel) begin
                  next_sub_out.data = SRI_IN.data;
               end else begin
                  next_sub_out.data[`SCIC_P_BIT] = p_one;
               end
               // link CRC bit replaced by the local one
               next_sub_out.data[`SCIC_Q_BIT] =
                  ~crc_val[15 - int'(c_idx[3:0])];
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         running <= 1'b0;
         current_position <= `SCIC_POS_RST;
         frame_cnt <= 16'h0000;
         SUB_OUT <= '0;
      end else begin
         running <= next_running;
         current_position <= next_current_position;
         frame_cnt <= next_frame_cnt;
         SUB_OUT <= next_sub_out;
      end
   end

   // checks
   a_init_clears: assert property (@(posedge REF_CLK) disable iff (SRST)
      init_frame && BYTE_TICK && !(wr_pos && WDATA[`SCIC_INIT_BIT])
      |=> !init_frame)
      else $error("init bit not cleared");

   a_preset_load: assert property (@(posedge REF_CLK) disable iff (SRST)
      init_frame && BYTE_TICK
      |=> running && current_position == $past(preset_position))
      else $error("preset not loaded");

   a_pos_wrap: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && current_position == LAST |=> current_position == 7'h00)
      else $error("position did not wrap");

   a_pos_step: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && current_position != LAST
      |=> current_position == $past(current_position) + 7'h01)
      else $error("position did not step");

   a_pos_read: assert property (@(posedge REF_CLK) disable iff (SRST)
      RD && ADDR == `SCIC_POS_OFS
      |=> RDATA == {$past(init_frame), $past(current_position)})
      else $error("position read wrong");

   a_sync_bytes: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && current_position < `SCIC_Q_FIRST
      |=> SUB_OUT.valid && SUB_OUT.data == 8'h00
          && (SUB_OUT.s0 ^ SUB_OUT.s1))
      else $error("sync byte wrong");

   a_bypass_pass: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && ext_sel && slot == scic_pkg::SLOT_DATA
      |=> SUB_OUT.data == $past(SRI_IN.data))
      else $error("link byte not passed");

   a_auto_rw: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && !ext_sel && current_position >= `SCIC_Q_FIRST
      |=> SUB_OUT.data[5:0] == 6'h00 && SUB_OUT.data[7] == $past(p_one))
      else $error("auto channels wrong");

   a_crc_out: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && current_position == CRC_POS
      |=> SUB_OUT.data[`SCIC_Q_BIT] == ~$past(crc_val[15]))
      else $error("crc bit wrong");

   a_sync_check: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && ext_sel && SRI_IN.sync && current_position != 7'h00
      |=> SYNC_ERR
          ##1 (SYNC_ERR || $past(wr_mode && WDATA[`SCIC_SERR_BIT])))
      else $error("sync error not flagged");

   a_serr_hold: assert property (@(posedge REF_CLK) disable iff (SRST)
      SYNC_ERR && !(wr_mode && WDATA[`SCIC_SERR_BIT]) |=> SYNC_ERR)
      else $error("sync error not sticky");

   a_rdata_idle: assert property (@(posedge REF_CLK) disable iff (SRST)
      !RD |=> RDATA == 8'h00)
      else $error("read data not idle");

   a_out_idle: assert property (@(posedge REF_CLK) disable iff (SRST)
      !emit |=> !SUB_OUT.valid && SUB_OUT.data == 8'h00)
      else $error("byte emitted without tick");

   a_init_set: assert property (@(posedge REF_CLK) disable iff (SRST)
      wr_pos && WDATA[`SCIC_INIT_BIT] |=> init_frame)
      else $error("init bit not set");

   a_preset_wr: assert property (@(posedge REF_CLK) disable iff (SRST)
      wr_pos |=> preset_position == $past(WDATA[6:0]))
      else $error("preset not written");

   a_mode_write: assert property (@(posedge REF_CLK) disable iff (SRST)
      wr_mode |=> ext_sel == $past(WDATA[`SCIC_EXT_BIT]))
      else $error("source select not written");

   a_crc_restart: assert property (@(posedge REF_CLK) disable iff (SRST)
      emit && current_position == 7'h01 |=> crc_val == `SCIC_CRC_INIT)
      else $error("crc not restarted");

   c_init_done: cover property (@(posedge REF_CLK) disable iff (SRST)
      init_frame ##1 !init_frame && running);
   c_wrap: cover property (@(posedge REF_CLK) disable iff (SRST)
      emit && current_position == LAST);
   c_sync_err: cover property (@(posedge REF_CLK) disable iff (SRST)
      $rose(SYNC_ERR));
   c_bypass_byte: cover property (@(posedge REF_CLK) disable iff (SRST)
      emit && ext_sel && slot == scic_pkg::SLOT_DATA);
   c_init_write: cover property (@(posedge REF_CLK) disable iff (SRST)
      wr_pos && WDATA[`SCIC_INIT_BIT]);

endmodule : scic_subcode_insert

/* File: dv/scic_link_model.sv */
`timescale 1ns/10ps

module scic_link_model #(
   parameter int FRAME_LEN = 98
) (
   input wire logic clk,
   input wire logic tick,
   input wire logic load,
   input wire logic [6:0] load_pos,
   input wire logic [7:0] salt,
   input wire logic bad_sync,
   output scic_pkg::scic_link_type link
);
   logic [6:0] pos = 7'h00;
   logic ready = 1'b0;
   logic [8:0] junk = 9'h0AA;

   always_ff @(posedge clk) begin
      junk <= ~junk;
      if (load) begin
         ready <= 1'b1;
         pos <= load_pos;
      end else if (tick) begin
         pos <= (pos == 7'(FRAME_LEN - 1)) ? 7'h00 : pos + 7'h01;
      end
   end

   // line toggles until the encoder side is primed
   assign link = ready ? {(pos == 7'h00) ^ bad_sync, salt ^ {1'b0, pos}}
                       : junk;
endmodule : scic_link_model

/* File: dv/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
   localparam int FL = 98;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic tick = 1'b0;
   logic load = 1'b0;
   logic bad = 1'b0;
   logic [6:0] lpos = 7'h00;
   logic [7:0] salt = 8'h00;
   scic_pkg::scic_link_type lnk;
   scic_pkg::scic_out_type sub;
   logic serr;
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 32'h53e163f2;
   logic [15:0] crc = 16'h0000;
   logic [6:0] epos = 7'h00;
   logic [6:0] pre = 7'h00;
   logic run = 1'b0;
   logic pend = 1'b0;
   logic ext = 1'b0;
   logic pval = 1'b0;
   logic [7:0] qctl = 8'h00;
   logic [15:0] fcnt = 16'h0000;

   scic_subcode_insert #(.FRAME_LEN(FL)) i_dut (.REF_CLK(clk), .SRST(srst),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .BYTE_TICK(tick), .SRI_IN(lnk), .SUB_OUT(sub), .SYNC_ERR(serr));

   scic_link_model #(.FRAME_LEN(FL)) i_link (.clk(clk), .tick(tick),
      .load(load), .load_pos(lpos), .salt(salt), .bad_sync(bad), .link(lnk));

   initial forever #2 clk = ~clk;

   task automatic check(input string name, input logic [10:0] seen,
                        input logic [10:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("rdata", {3'h0, rdata}, {3'h0, e});
   endtask : rd_reg

   task automatic do_tick;
      logic [10:0] e;
      scic_pkg::scic_link_type l;
      @(posedge clk);
      tick <= 1'b1;
      salt <= 8'($random(seed));
      load <= pend;
      lpos <= pre;
      @(posedge clk);
      tick <= 1'b0;
      load <= 1'b0;
      l = lnk;
      #1;
      if (!run || pend) begin
         check("idle", sub, 11'h000);
         if (pend) begin
            run = 1'b1;
            pend = 1'b0;
            epos = pre;
            crc = 16'h0000;
         end
      end else begin
         e = {1'b1, epos == 7'h00, epos == 7'h01, 8'h00};
         if (epos > 7'h01) begin
            e[7:0] = ext ? l.data : {pval, 7'h00};
            if (!ext && epos < 7'd10) e[6] = qctl[4'(7'd9 - epos)];
            // frame number sits in the last 16 Q data bits
            if (!ext && epos >= 7'd66) e[6] = fcnt[4'(7'd81 - epos)];
            if (epos >= 7'(FL - 16)) e[6] = ~crc[4'(7'(FL - 1) - epos)];
         end
         check("sub_out", sub, e);
         if (epos == 7'h01) crc = 16'h0000;
         else if (epos > 7'h01 && epos < 7'(FL - 16))
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ e[6]) ? 16'h1021 : 16'h0000);
         if (!ext && epos == 7'(FL - 1)) fcnt = fcnt + 16'h0001;
         epos = (epos == 7'(FL - 1)) ? 7'h00 : epos + 7'h01;
      end
      if ($random(seed) % 2) @(posedge clk);
   endtask : do_tick

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd_reg(8'h22, 8'h00);
      rd_reg(8'h30, 8'h00);
      rd_reg(8'h55, 8'h00);
      do_tick;
      $display("test reset done");
      qctl = 8'($random(seed));
      pval = 1'b1;
      wr_reg(8'h31, qctl);
      wr_reg(8'h30, 8'h02);
      rd_reg(8'h31, qctl);
      pend = 1'b1;
      wr_reg(8'h22, 8'h80);
      rd_reg(8'h22, 8'h80);
      do_tick;
      rd_reg(8'h22, 8'h00);
      repeat (200) do_tick;
      rd_reg(8'h22, {1'b0, epos});
      $display("test auto format done");
      ext = 1'b1;
      pval = 1'b0;
      wr_reg(8'h30, 8'h01);
      pre = 7'd95;
      pend = 1'b1;
      wr_reg(8'h22, 8'hDF);
      repeat (201) do_tick;
      rd_reg(8'h30, 8'h01);
      $display("test bypass done");
      bad <= 1'b1;
      repeat (3) do_tick;
      bad <= 1'b0;
      rd_reg(8'h30, 8'h81);
      check("sync_err", {10'h000, serr}, 11'h001);
      wr_reg(8'h30, 8'h81);
      rd_reg(8'h30, 8'h01);
      $display("test sync check done");
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
endmodule : tb_top
